// ==== rtl/ucs_ctrl_status.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module ucs_ctrl_status
	import ucs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire ucs_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire ucs_fmt_t fmt,
	input wire ucs_rx_bit_t rx_bit,
	input wire ucs_tx_stat_t tx_stat,
	output ucs_mode_t mode,
	output logic rx_int_pulse,
	output logic active,
	output logic irq
);

	// ************************************************************
	// bus decode
	// ************************************************************
	logic wr_ctrl;
	logic rd_ctrl;
	logic wr_mask;
	logic rd_stat;
	logic rd_mask;

	assign wr_ctrl = bus_req.we && (bus_req.addr == UCS_OFS_CTRL);
	assign rd_ctrl = bus_req.rd_req && (bus_req.addr == UCS_OFS_CTRL);
	assign wr_mask = bus_req.we && (bus_req.addr == UCS_OFS_IRQ_MASK);
	assign rd_stat = bus_req.rd_req && (bus_req.addr == UCS_OFS_IRQ_STAT);
	assign rd_mask = bus_req.rd_req && (bus_req.addr == UCS_OFS_IRQ_MASK);

	// ************************************************************
	// mode and enable bits
	// ************************************************************
	logic uart_mode_q;
	logic rx_en_q;
	logic slave_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			uart_mode_q <= UCS_CTRL_RST[UCS_BIT_MODE];
			rx_en_q <= UCS_CTRL_RST[UCS_BIT_RX_EN];
			slave_q <= UCS_CTRL_RST[UCS_BIT_SLAVE];
		end else if (wr_ctrl) begin
			uart_mode_q <= bus_req.wdata[UCS_BIT_MODE];
			rx_en_q <= bus_req.wdata[UCS_BIT_RX_EN];
			slave_q <= bus_req.wdata[UCS_BIT_SLAVE];
		end
	end

	// role only counts in synchronous mode
	always_comb begin
		mode.uart_mode = uart_mode_q;
		mode.spi_master = !uart_mode_q && !slave_q;
		mode.spi_slave = !uart_mode_q && slave_q;
		mode.rx_enable = rx_en_q;
	end

	// ************************************************************
	// receive frame tracker
	// ************************************************************
	ucs_rx_state_t rx_state_q;
	ucs_rx_state_t rx_state_d;
	logic [2:0] rx_cnt_q;
	logic [2:0] rx_cnt_d;
	logic rx_par_q;
	logic rx_par_d;
	logic rx_par_bad_q;
	logic rx_par_bad_d;
	logic rx_go;
	logic ev_rxb;
	logic ev_frm_err;
	logic ev_pe;

	// frames are only followed in asynchronous mode with the receiver on
	assign rx_go = uart_mode_q && rx_en_q;

	always_comb begin
		rx_state_d = rx_state_q;
		rx_cnt_d = rx_cnt_q;
		rx_par_d = rx_par_q;
		rx_par_bad_d = rx_par_bad_q;
		ev_rxb = 1'b0;
		ev_frm_err = 1'b0;
		ev_pe = 1'b0;
		if (!rx_go) begin
			rx_state_d = UCS_RX_IDLE;
		end else if (rx_bit.bit_stb) begin
			case (rx_state_q)
				UCS_RX_IDLE: begin
					// a strobe at the idle level is no start, stay put
					if (rx_bit.bit_val == fmt.start_level) begin
						rx_state_d = UCS_RX_DATA;
						rx_cnt_d = UCS_CNT_RST;
						rx_par_d = fmt.parity_odd;
						rx_par_bad_d = 1'b0;
					end
				end
				UCS_RX_DATA: begin
					rx_par_d = rx_par_q ^ rx_bit.bit_val;
					rx_cnt_d = rx_cnt_q + 3'h1;
					if (rx_cnt_q == UCS_DATA_LAST) begin
						rx_state_d = fmt.nine_bit ? UCS_RX_NINTH : UCS_RX_STOP1;
					end
				end
				UCS_RX_NINTH: begin
					// ninth bit carries parity only when parity is on
					rx_par_bad_d = fmt.parity_en && (rx_bit.bit_val != rx_par_q);
					rx_state_d = UCS_RX_STOP1;
				end
				UCS_RX_STOP1: begin
					ev_pe = rx_par_bad_q;
					if (rx_bit.bit_val == fmt.stop_level) begin
						ev_rxb = 1'b1;
						rx_state_d = fmt.two_stop ? UCS_RX_STOP2 : UCS_RX_IDLE;
					end else begin
						// broken frame: no ready flag
						ev_frm_err = 1'b1;
						rx_state_d = UCS_RX_IDLE;
					end
				end
				UCS_RX_STOP2: begin
					// second stop is judged a full bit after the first
					ev_frm_err = (rx_bit.bit_val != fmt.stop_level);
					rx_state_d = UCS_RX_IDLE;
				end
				default: begin
					rx_state_d = UCS_RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_state_q <= UCS_RX_IDLE;
			rx_cnt_q <= UCS_CNT_RST;
		end else begin
			rx_state_q <= rx_state_d;
			rx_cnt_q <= rx_cnt_d;
		end
	end

	// parity runs over the data bits only, seeded with the odd or even choice
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_par_q <= 1'b0;
			rx_par_bad_q <= 1'b0;
		end else begin
			rx_par_q <= rx_par_d;
			rx_par_bad_q <= rx_par_bad_d;
		end
	end

	// same edge as the receive-ready flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_int_pulse <= 1'b0;
		end else begin
			rx_int_pulse <= ev_rxb;
		end
	end

	// ************************************************************
	// transmit completion
	// ************************************************************
	logic ev_txb;

	// a byte still waiting in the buffer means this was not the last one
	assign ev_txb = tx_stat.byte_sent && tx_stat.buf_empty;

	// ************************************************************
	// activity
	// ************************************************************
	logic active_q;

	// next-state view, so the flag drops with the last stop strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			active_q <= 1'b0;
		end else begin
			active_q <= tx_stat.shifting || (rx_state_d != UCS_RX_IDLE);
		end
	end

	assign active = active_q;

	// ************************************************************
	// sticky status flags of the control register
	// ************************************************************
	logic [3:0] csr_set;
	logic [3:0] csr_clr;
	logic [3:0] csr_flags;

	always_comb begin
		csr_set = {ev_frm_err, ev_pe, ev_rxb, ev_txb};
		csr_clr = '0;
		// a 1 written to a flag leaves it alone
		if (wr_ctrl) begin
			csr_clr = ~bus_req.wdata[UCS_BIT_FRM_ERR:UCS_BIT_TXB];
		end
	end

	ucs_sticky #(
		.W(4)
	) u_csr_flags (
		.clk(clk),
		.nrst(nrst),
		.set(csr_set),
		.clr(csr_clr),
		.q(csr_flags)
	);

	// ************************************************************
	// interrupt status and mask
	// ************************************************************
	logic [UCS_EV_W-1:0] irq_set;
	logic [UCS_EV_W-1:0] irq_clr;
	logic [UCS_EV_W-1:0] irq_stat;
	logic [UCS_EV_W-1:0] irq_mask_q;
	logic irq_q;

	always_comb begin
		irq_set = '0;
		irq_set[UCS_EV_RXB] = ev_rxb;
		irq_set[UCS_EV_FRM_ERR] = ev_frm_err;
		irq_set[UCS_EV_PE] = ev_pe;
		irq_set[UCS_EV_TXB] = ev_txb;
		irq_clr = {UCS_EV_W{rd_stat}};
	end

	// read clears, but an event in the read cycle survives it
	ucs_sticky #(
		.W(UCS_EV_W)
	) u_irq_stat (
		.clk(clk),
		.nrst(nrst),
		.set(irq_set),
		.clr(irq_clr),
		.q(irq_stat)
	);

	// the mask only gates the output, events still land in status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_mask_q <= UCS_IRQ_MASK_RST;
		end else if (wr_mask) begin
			irq_mask_q <= bus_req.wdata[UCS_EV_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat & irq_mask_q);
		end
	end

	// one cycle behind the status bits
	assign irq = irq_q;

	// ************************************************************
	// read data
	// ************************************************************
	logic [7:0] ctrl_view;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	always_comb begin
		ctrl_view = '0;
		ctrl_view[UCS_BIT_MODE] = uart_mode_q;
		ctrl_view[UCS_BIT_RX_EN] = rx_en_q;
		ctrl_view[UCS_BIT_SLAVE] = slave_q;
		ctrl_view[UCS_BIT_FRM_ERR:UCS_BIT_TXB] = csr_flags;
		ctrl_view[UCS_BIT_ACT] = active_q;
	end

	// unmapped addresses read as zero
	always_comb begin
		rdata_d = '0;
		if (rd_ctrl) begin
			rdata_d = ctrl_view;
		end else if (rd_stat) begin
			rdata_d[UCS_EV_W-1:0] = irq_stat;
		end else if (rd_mask) begin
			rdata_d[UCS_EV_W-1:0] = irq_mask_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign bus_rdata = rdata_q;

endmodule // ucs_ctrl_status

// ==== common/ucs_pkg.sv ====
package ucs_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] UCS_OFS_CTRL = 8'hf8;
	localparam logic [7:0] UCS_OFS_IRQ_STAT = 8'he0;
	localparam logic [7:0] UCS_OFS_IRQ_MASK = 8'he1;

	localparam logic [7:0] UCS_CTRL_RST = 8'h00;
	localparam logic [3:0] UCS_IRQ_MASK_RST = 4'h0;

	// ************************************************************
	// control/status field positions
	// ************************************************************
	localparam int UCS_BIT_MODE = 7;
	localparam int UCS_BIT_RX_EN = 6;
	localparam int UCS_BIT_SLAVE = 5;
	localparam int UCS_BIT_FRM_ERR = 4;
	localparam int UCS_BIT_PE = 3;
	localparam int UCS_BIT_RXB = 2;
	localparam int UCS_BIT_TXB = 1;
	localparam int UCS_BIT_ACT = 0;

	// ************************************************************
	// event positions in the interrupt status and mask registers
	// ************************************************************
	localparam int UCS_EV_RXB = 0;
	localparam int UCS_EV_FRM_ERR = 1;
	localparam int UCS_EV_PE = 2;
	localparam int UCS_EV_TXB = 3;
	localparam int UCS_EV_W = 4;

	// ************************************************************
	// receive frame counts
	// ************************************************************
	localparam logic [2:0] UCS_DATA_LAST = 3'h7;
	localparam logic [2:0] UCS_CNT_RST = 3'h0;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic start_level;
		logic stop_level;
		logic two_stop;
		logic parity_en;
		logic nine_bit;
		logic parity_odd;
	} ucs_fmt_t;

	typedef struct packed {
		logic bit_stb;
		logic bit_val;
	} ucs_rx_bit_t;

	typedef struct packed {
		logic shifting;
		logic byte_sent;
		logic buf_empty;
	} ucs_tx_stat_t;

	typedef struct packed {
		logic uart_mode;
		logic spi_master;
		logic spi_slave;
		logic rx_enable;
	} ucs_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic rd_req;
	} ucs_bus_req_t;

	typedef enum logic [2:0] {
		UCS_RX_IDLE,
		UCS_RX_DATA,
		UCS_RX_NINTH,
		UCS_RX_STOP1,
		UCS_RX_STOP2
	} ucs_rx_state_t;

endpackage

// ==== rtl/ucs_sticky.sv ====
`timescale 1ns/100ps
module ucs_sticky
	import ucs_pkg::*;
#(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);

	logic [W-1:0] q_q;

	// set wins over a clear landing in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q_q <= '0;
		end else begin
			q_q <= (q_q & ~clr) | set;
		end
	end

	assign q = q_q;

endmodule // ucs_sticky

// ==== verification/ucs_ctrl_status_properties.sv ====
`timescale 1ns/100ps
module ucs_ctrl_status_properties
	import ucs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire ucs_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire ucs_fmt_t fmt,
	input wire ucs_rx_bit_t rx_bit,
	input wire ucs_tx_stat_t tx_stat,
	input wire ucs_mode_t mode,
	input wire logic rx_int_pulse,
	input wire logic active,
	input wire logic irq
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic ctl_wr;
	assign ctl_wr = bus_req.we && bus_req.addr == UCS_OFS_CTRL;
	mode_sel_a: assert property (
		ctl_wr |=> mode.uart_mode == $past(bus_req.wdata[7]))
		else $error("mode bit not taken");
	role_sel_a: assert property (
		ctl_wr |=> mode.spi_slave == $past(!bus_req.wdata[7] && bus_req.wdata[5]))
		else $error("role bit not taken");
	mode_hold_a: assert property (
		!ctl_wr |=> $stable(mode))
		else $error("mode moved without write");
	rx_gate_a: assert property (
		rx_int_pulse |-> $past(mode.uart_mode && mode.rx_enable))
		else $error("receive while disabled");
	rx_pulse_a: assert property (
		rx_int_pulse |=> !rx_int_pulse)
		else $error("receive pulse too long");
	rx_stop_a: assert property (
		rx_int_pulse |-> $past(rx_bit.bit_stb && rx_bit.bit_val == fmt.stop_level))
		else $error("receive pulse without good stop");
	// past reset guard: a shifter busy during reset must not count
	act_tx_a: assert property (
		$past(nrst) && $past(tx_stat.shifting) |-> active)
		else $error("busy not shown");
	act_src_a: assert property (
		active && !$past(tx_stat.shifting) |-> $past(mode.uart_mode && mode.rx_enable))
		else $error("busy while idle");
	rdata_zero_a: assert property (
		!$past(bus_req.rd_req) |-> bus_rdata == 8'h00)
		else $error("read data outside read slot");
	cover property (rx_int_pulse);
	cover property ($rose(irq));
	cover property (active ##1 !active);
endmodule // ucs_ctrl_status_properties

bind ucs_ctrl_status ucs_ctrl_status_properties u_props(.clk, .nrst, .bus_req, .bus_rdata,
	.fmt, .rx_bit, .tx_stat, .mode, .rx_int_pulse, .active, .irq);

// ==== verification/ucs_peer.sv ====
`timescale 1ns/100ps
module ucs_peer
	import ucs_pkg::*;
(
	input wire logic clk,
	output ucs_rx_bit_t rx_bit,
	output ucs_tx_stat_t tx_stat
);
	// ****
	// serial peer and shifter stand-in
	// ****
	initial begin
		rx_bit = '0;
		tx_stat = 3'h1;
	end
	// line shows the inverse between strobes so no stale level looks valid
	task automatic bit_out(input logic v);
		@(posedge clk);
		rx_bit <= '{1'b1, v};
		@(posedge clk);
		rx_bit <= '{1'b0, !v};
		repeat (2) @(posedge clk);
	endtask
	task automatic frame(input logic [7:0] d, input logic b9, input logic has9, input logic s1);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i]);
		end
		if (has9) begin
			bit_out(b9);
		end
		bit_out(s1);
	endtask
	task automatic send_tx(input logic last);
		@(posedge clk);
		tx_stat <= '{1'b1, 1'b0, last};
		repeat (3) @(posedge clk);
		tx_stat <= '{1'b0, 1'b1, last};
		@(posedge clk);
		tx_stat <= 3'h1;
	endtask
endmodule // ucs_peer

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
	import ucs_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	ucs_bus_req_t bus_req = '0;
	ucs_fmt_t fmt = 6'h10;
	logic [7:0] bus_rdata;
	ucs_rx_bit_t rx_bit;
	ucs_tx_stat_t tx_stat;
	ucs_mode_t mode;
	logic rx_int_pulse;
	logic active;
	logic irq;
	int error_cnt = 0;
	int comparisons = 0;
	always #25 clk = !clk;
	ucs_ctrl_status u_ucs_ctrl_status(.clk, .nrst, .bus_req, .bus_rdata, .fmt, .rx_bit,
		.tx_stat, .mode, .rx_int_pulse, .active, .irq);
	ucs_peer u_ucs_peer(.clk, .rx_bit, .tx_stat);
	// ****
	// bus and compare tasks
	// ****
	task automatic complete_run();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 chk(bus_rdata, e);
	endtask
	initial begin
		#1000000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1 chk({4'h0, mode}, 8'h04);
		rd(UCS_OFS_CTRL, 8'h00);
		rd(8'h10, 8'h00);
		wr(UCS_OFS_CTRL, 8'h20);
		#1 chk({4'h0, mode}, 8'h02);
		wr(UCS_OFS_CTRL, 8'h80);
		u_ucs_peer.frame(8'h55, 1'b0, 1'b0, 1'b1);
		rd(UCS_OFS_CTRL, 8'h80);
		wr(UCS_OFS_IRQ_MASK, 8'h0f);
		rd(UCS_OFS_IRQ_MASK, 8'h0f);
		wr(UCS_OFS_CTRL, 8'hc0);
		#1 chk({4'h0, mode}, 8'h09);
		u_ucs_peer.frame(8'ha5, 1'b0, 1'b0, 1'b1);
		#1 chk({7'h0, irq}, 8'h01);
		rd(UCS_OFS_CTRL, 8'hc4);
		rd(UCS_OFS_IRQ_STAT, 8'h01);
		rd(UCS_OFS_IRQ_STAT, 8'h00);
		wr(UCS_OFS_CTRL, 8'hc0);
		rd(UCS_OFS_CTRL, 8'hc0);
		// even parity over one set bit wants a ninth bit of 1
		@(posedge clk);
		fmt <= 6'h16;
		u_ucs_peer.frame(8'h01, 1'b0, 1'b1, 1'b1);
		rd(UCS_OFS_CTRL, 8'hcc);
		rd(UCS_OFS_IRQ_STAT, 8'h05);
		wr(UCS_OFS_CTRL, 8'hc0);
		u_ucs_peer.frame(8'h01, 1'b1, 1'b1, 1'b1);
		rd(UCS_OFS_CTRL, 8'hc4);
		// odd parity over one set bit wants a ninth bit of 0
		@(posedge clk);
		fmt <= 6'h17;
		u_ucs_peer.frame(8'h01, 1'b1, 1'b1, 1'b1);
		rd(UCS_OFS_CTRL, 8'hcc);
		rd(UCS_OFS_IRQ_STAT, 8'h05);
		wr(UCS_OFS_CTRL, 8'hc4);
		@(posedge clk);
		fmt <= 6'h10;
		u_ucs_peer.frame(8'h3c, 1'b0, 1'b0, 1'b0);
		rd(UCS_OFS_CTRL, 8'hd4);
		wr(UCS_OFS_CTRL, 8'hc0);
		@(posedge clk);
		fmt <= 6'h18;
		u_ucs_peer.frame(8'h3c, 1'b0, 1'b0, 1'b1);
		rd(UCS_OFS_CTRL, 8'hc5);
		u_ucs_peer.bit_out(1'b0);
		rd(UCS_OFS_CTRL, 8'hd4);
		wr(UCS_OFS_CTRL, 8'hc0);
		rd(UCS_OFS_IRQ_STAT, 8'h03);
		wr(UCS_OFS_IRQ_MASK, 8'h00);
		u_ucs_peer.frame(8'h81, 1'b0, 1'b0, 1'b1);
		u_ucs_peer.bit_out(1'b1);
		#1 chk({7'h0, irq}, 8'h00);
		rd(UCS_OFS_IRQ_STAT, 8'h01);
		wr(UCS_OFS_IRQ_MASK, 8'h0f);
		wr(UCS_OFS_CTRL, 8'hc0);
		fork
			u_ucs_peer.send_tx(1'b0);
			begin
				repeat (3) @(posedge clk);
				#1 chk({7'h0, active}, 8'h01);
			end
		join
		rd(UCS_OFS_CTRL, 8'hc0);
		u_ucs_peer.send_tx(1'b1);
		rd(UCS_OFS_CTRL, 8'hc2);
		rd(UCS_OFS_IRQ_STAT, 8'h08);
		complete_run();
	end
endmodule // tb_top
